// File: rtl/hsl_homing_limit.sv
// Homing sequencer and software limit supervisor with APB registers
//
// Contract
// [R01] Homing uses negative limit, positive limit, reference cam, zero pulse.
// [R02] Type 5 from cam active going positive: zero after cam falling edge.
// [R03] Type 6 from cam active going positive: reverse at fall, zero after rise.
// [R04] Types 5/6 start negative cam inactive; 5 reverses at rise.
// [R05] Types 7-10 start positive, cam inactive; per-type reversal and zero edge.
// [R06] Types 7/8 from cam active go negative; 8 reverses at falling edge.
// [R07] Types 9/10 from cam active go positive; 9 reverses when cam clears.
// [R08] Types 7-10 reverse at positive limit, then continue their pattern.
// [R09] Types 11-14 mirror types 7-10 with the negative limit switch.
// [R10] Types 13/14 from cam active go negative; 13 reverses, 14 zeroes.
// [R11] Types 11/12 from cam active go positive; 12 reverses at fall.
// [R12] Types 11-14 reverse at negative limit, then continue their pattern.
// [R13] Type codes 15, 16, 31, 32 are undefined and never start homing.
// [R14] Types 17-30 follow base patterns but zero on the cam edge itself; the code takes only 21-30 and refuses 17-20.
// [R15] Zero-pulse-only type zeroes on first zero pulse in travel direction.
// [R16] Type 35 adopts present position as zero without resetting position.
// [R17] Soft limits apply in positioning mode and only after homing completes.
// [R18] Soft limits are disabled when both limits equal zero.
// [R19] Out-of-range absolute or relative target: no move, run limit reaction.
// [R20] Endless move stops at soft limit with reaction and always rapid stop.
// [R21] Zero event loads position with zero value and sets homing done.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module hsl_homing_limit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lim_neg_in,
  input  wire logic        lim_pos_in,
  input  wire logic        ref_cam_in,
  input  wire logic        zero_pulse_in,
  input  wire logic        step_inc_in,
  input  wire logic        step_dec_in,
  output logic             drive_run,
  output logic             drive_dir_pos,
  output logic             drive_creep,
  output logic             rapid_stop,
  output logic             limit_fault,
  output logic             limit_warn,
  output logic             homing_done
);
  // ==========================================================
  // Pin synchronisers and edge history
  logic [5:0] sync1_ff, sync2_ff, prev_ff;
  logic [5:0] nxt_sync1, nxt_sync2, nxt_prev;

  // Two stages per pin, then one history stage for edges
  always_comb begin
    nxt_sync1 = sync1_ff;
    nxt_sync2 = sync2_ff;
    nxt_prev  = prev_ff;
    if (ce) begin
      nxt_sync1 = {step_dec_in, step_inc_in, zero_pulse_in,
                   ref_cam_in, lim_pos_in, lim_neg_in}; // [R01]
      nxt_sync2 = sync1_ff;
      nxt_prev  = sync2_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      prev_ff  <= 6'h00;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  logic lim_n, lim_p, cam, cam_rise, cam_fall, zp_rise, inc_rise, dec_rise;
  assign lim_n    = sync2_ff[0];
  assign lim_p    = sync2_ff[1];
  assign cam      = sync2_ff[2];
  assign cam_rise = sync2_ff[2] & ~prev_ff[2];
  assign cam_fall = ~sync2_ff[2] & prev_ff[2];
  assign zp_rise  = sync2_ff[3] & ~prev_ff[3];
  assign inc_rise = sync2_ff[4] & ~prev_ff[4];
  assign dec_rise = sync2_ff[5] & ~prev_ff[5];

  // ==========================================================
  // APB slave: one wait cycle, write lands with pready high
  logic        pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic        nxt_pready, nxt_pslverr;
  logic [31:0] nxt_prdata;
  logic        wr_now, addr_ok;

  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= hsl_pkg::ADDR_POS);
  assign wr_now  = psel & penable & pready_ff & pwrite & addr_ok;

  // ==========================================================
  // Control state
  hsl_pkg::hsl_state_t state_ff, nxt_state;
  logic [5:0]         type_ff, nxt_type;
  logic [1:0]         react_ff, nxt_react;
  logic               posmode_ff, nxt_posmode;
  logic signed [31:0] slp_ff, sln_ff, target_ff, zero_ff, pos_ff, goal_ff;
  logic signed [31:0] nxt_slp, nxt_sln, nxt_target, nxt_zero, nxt_pos;
  logic signed [31:0] nxt_goal, rel_goal, req_goal;
  logic dir_ff, homed_ff, fault_ff, warn_ff, terr_ff, rstop_ff;
  logic run_ff, creep_ff, final_ff, edge_ff;
  logic nxt_dir, nxt_homed, nxt_fault, nxt_warn, nxt_terr, nxt_rstop;
  logic nxt_run, nxt_creep, nxt_final, nxt_edge;

  // Status word shows the sequencer's own state
  logic [31:0] status_w;
  logic        lim_active;
  assign status_w = {24'h000000, lim_active, terr_ff, warn_ff, fault_ff,
                     (state_ff == hsl_pkg::ST_ARMED), dir_ff, run_ff,
                     homed_ff};

  // Read mux and handshake
  always_comb begin
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (ce && psel && penable && !pready_ff) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !addr_ok;
      unique case (paddr)
        hsl_pkg::ADDR_CTRL:   nxt_prdata = {22'h000000, react_ff,
                                            1'b0, posmode_ff, type_ff};
        hsl_pkg::ADDR_STATUS: nxt_prdata = status_w;
        hsl_pkg::ADDR_SLP:    nxt_prdata = slp_ff;
        hsl_pkg::ADDR_SLN:    nxt_prdata = sln_ff;
        hsl_pkg::ADDR_TARGET: nxt_prdata = target_ff;
        hsl_pkg::ADDR_ZERO:   nxt_prdata = zero_ff;
        hsl_pkg::ADDR_POS:    nxt_prdata = pos_ff;
        default:              nxt_prdata = 32'h0000_0000;
      endcase
    end else if (ce) begin
      nxt_pready = 1'b0;
    end else begin
      nxt_pready  = pready_ff;
      nxt_pslverr = pslverr_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= hsl_pkg::WORD_RST;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // ==========================================================
  // Homing type decode
  logic       edge_only, type_ok, is_zp, mirror;
  logic [5:0] base, idx;
  logic [4:0] entry;
  logic       fin_pos, edge_rise, trig_rise, start_pos;

  always_comb begin
    edge_only = (type_ff >= hsl_pkg::HT_EDGE_LO) &&
                (type_ff <= hsl_pkg::HT_EDGE_HI);                 // [R14]
    base      = edge_only ? type_ff - hsl_pkg::HT_EDGE_OFS : type_ff;
    // 15, 16, 31, 32 and all others outside the table except 33-35 stay refused
    type_ok   = (base >= hsl_pkg::HT_FIRST) &&
                (base <= hsl_pkg::HT_LAST);                       // [R13]
    is_zp     = (type_ff == hsl_pkg::HT_ZP_POS) ||
                (type_ff == hsl_pkg::HT_ZP_NEG);
    mirror    = base >= hsl_pkg::HT_MIRROR;                       // [R09]
    idx       = mirror ? base - hsl_pkg::HT_MIR_OFS - hsl_pkg::HT_FIRST
                       : base - hsl_pkg::HT_FIRST;
    entry     = type_ok ? hsl_pkg::HT_TABLE[idx[2:0]] : 5'h00;
    fin_pos   = entry[4] ^ mirror;
    edge_rise = entry[3];
    trig_rise = entry[2];
    start_pos = (cam ? entry[1] : entry[0]) ^ mirror; // [R02] [R04] [R06]
  end

  // ==========================================================
  // Soft limit window
  logic goal_out, end_hit, lim_here, qual_edge, trig_edge;
  logic cmd_home, cmd_abs, cmd_rel, cmd_ep, cmd_en, cmd_stop, cmd_clr;
  logic idle;

  assign lim_active = homed_ff && posmode_ff &&
                      !(slp_ff == 32'sh0 && sln_ff == 32'sh0); // [R17] [R18]
  assign rel_goal   = pos_ff + target_ff;
  assign req_goal   = pwdata[hsl_pkg::CMD_REL] ? rel_goal : target_ff;
  assign goal_out   = lim_active && (req_goal > slp_ff ||
                                     req_goal < sln_ff);          // [R19]
  assign end_hit    = lim_active && (dir_ff ? pos_ff >= slp_ff
                                            : pos_ff <= sln_ff);  // [R20]
  assign lim_here   = dir_ff ? lim_p : lim_n;            // [R08] [R12]
  assign qual_edge  = edge_rise ? cam_rise : cam_fall;
  assign trig_edge  = trig_rise ? cam_rise : cam_fall;
  assign idle       = state_ff == hsl_pkg::ST_IDLE;

  // Command strobes are the write into the command word
  logic cmd_wr;
  assign cmd_wr   = wr_now && (paddr == hsl_pkg::ADDR_CMD);
  assign cmd_home = cmd_wr && pwdata[hsl_pkg::CMD_HOME];
  assign cmd_abs  = cmd_wr && pwdata[hsl_pkg::CMD_ABS];
  assign cmd_rel  = cmd_wr && pwdata[hsl_pkg::CMD_REL];
  assign cmd_ep   = cmd_wr && pwdata[hsl_pkg::CMD_END_POS];
  assign cmd_en   = cmd_wr && pwdata[hsl_pkg::CMD_END_NEG];
  assign cmd_stop = cmd_wr && pwdata[hsl_pkg::CMD_STOP];
  assign cmd_clr  = cmd_wr && pwdata[hsl_pkg::CMD_CLR];

  // Next control state: registers, position, sequencer
  always_comb begin
    nxt_state = state_ff;   nxt_type   = type_ff;   nxt_react = react_ff;
    nxt_posmode = posmode_ff; nxt_slp  = slp_ff;    nxt_sln   = sln_ff;
    nxt_target = target_ff; nxt_zero   = zero_ff;   nxt_pos   = pos_ff;
    nxt_goal  = goal_ff;    nxt_dir    = dir_ff;    nxt_homed = homed_ff;
    nxt_fault = fault_ff;   nxt_warn   = warn_ff;   nxt_terr  = terr_ff;
    nxt_rstop = rstop_ff;   nxt_final  = final_ff;  nxt_edge  = edge_ff;
    if (ce) begin
      nxt_rstop = 1'b0;
      if (inc_rise && !dec_rise) nxt_pos = pos_ff + 32'sd1;
      if (dec_rise && !inc_rise) nxt_pos = pos_ff - 32'sd1;
      if (wr_now) begin
        unique case (paddr)
          hsl_pkg::ADDR_CTRL: begin
            nxt_type    = pwdata[hsl_pkg::CTRL_TYPE_LSB +: 6];
            nxt_posmode = pwdata[hsl_pkg::CTRL_POSMODE];
            nxt_react   = pwdata[hsl_pkg::CTRL_REACT_LSB +: 2];
          end
          hsl_pkg::ADDR_SLP:    nxt_slp    = pwdata;
          hsl_pkg::ADDR_SLN:    nxt_sln    = pwdata;
          hsl_pkg::ADDR_TARGET: nxt_target = pwdata;
          hsl_pkg::ADDR_ZERO:   nxt_zero   = pwdata;
          default: ;
        endcase
      end
      // Clear first so that a same-cycle event below wins
      if (cmd_clr) begin
        nxt_fault = 1'b0;
        nxt_warn  = 1'b0;
        nxt_terr  = 1'b0;
      end
      unique case (state_ff)
        hsl_pkg::ST_IDLE: begin
          if (cmd_home) begin
            if (type_ff == hsl_pkg::HT_KEEP) begin
              nxt_homed = 1'b1;                                   // [R16]
            end else if (is_zp) begin
              nxt_homed = 1'b0;
              nxt_dir   = type_ff == hsl_pkg::HT_ZP_POS;
              nxt_final = nxt_dir;
              nxt_state = hsl_pkg::ST_ARMED;                      // [R15]
            end else if (type_ok) begin
              nxt_homed = 1'b0;
              nxt_dir   = start_pos;                // [R05] [R07] [R10] [R11]
              nxt_final = fin_pos;
              nxt_edge  = edge_only;
              nxt_state = hsl_pkg::ST_SEEK;
            end else begin
              nxt_terr  = 1'b1;                                   // [R13]
            end
          end else if ((cmd_abs || cmd_rel) && posmode_ff) begin
            if (goal_out) begin
              if (react_ff == hsl_pkg::REACTION_WARN) begin
                nxt_warn = 1'b1;                                  // [R19]
              end else if (react_ff != hsl_pkg::REACTION_NO_ERROR) begin
                nxt_fault = 1'b1;
                nxt_rstop = 1'b1;
              end
            end else if (req_goal != pos_ff) begin
              nxt_goal  = req_goal;
              nxt_dir   = req_goal > pos_ff;
              nxt_state = hsl_pkg::ST_MOVE;
            end
          end else if ((cmd_ep || cmd_en) && posmode_ff) begin
            nxt_dir   = cmd_ep;
            nxt_state = hsl_pkg::ST_ENDLESS;
          end
        end
        hsl_pkg::ST_SEEK: begin
          if (cmd_stop) begin
            nxt_state = hsl_pkg::ST_IDLE;
          end else if (lim_here) begin
            nxt_dir = !dir_ff;                            // [R08] [R12]
          end else if (dir_ff != final_ff) begin
            if (trig_edge) nxt_dir = !dir_ff;     // [R03] [R04] [R06] [R09]
          end else if (qual_edge) begin
            if (edge_ff) begin
              nxt_pos   = zero_ff;                        // [R14] [R21]
              nxt_homed = 1'b1;
              nxt_state = hsl_pkg::ST_IDLE;
            end else begin
              nxt_state = hsl_pkg::ST_ARMED;              // [R02] [R05]
            end
          end
        end
        hsl_pkg::ST_ARMED: begin
          if (cmd_stop) begin
            nxt_state = hsl_pkg::ST_IDLE;
          end else if (zp_rise) begin
            nxt_pos   = zero_ff;                          // [R21]
            nxt_homed = 1'b1;
            nxt_state = hsl_pkg::ST_IDLE;
          end else if (lim_here) begin
            nxt_dir = !dir_ff;
            if (!is_zp) nxt_state = hsl_pkg::ST_SEEK;
            else nxt_final = !dir_ff;
          end
        end
        hsl_pkg::ST_MOVE: begin
          if (cmd_stop || pos_ff == goal_ff) nxt_state = hsl_pkg::ST_IDLE;
        end
        hsl_pkg::ST_ENDLESS: begin
          if (end_hit) begin
            nxt_rstop = 1'b1;                                     // [R20]
            nxt_state = hsl_pkg::ST_IDLE;
            if (react_ff == hsl_pkg::REACTION_WARN) nxt_warn = 1'b1;
            else if (react_ff != hsl_pkg::REACTION_NO_ERROR) nxt_fault = 1'b1;
          end else if (cmd_stop) begin
            nxt_state = hsl_pkg::ST_IDLE;
          end
        end
      endcase
    end
    nxt_run   = nxt_state != hsl_pkg::ST_IDLE;
    nxt_creep = (nxt_state == hsl_pkg::ST_SEEK ||
                 nxt_state == hsl_pkg::ST_ARMED) && (nxt_dir == nxt_final);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= hsl_pkg::ST_IDLE;
      type_ff    <= hsl_pkg::TYPE_RST;
      react_ff   <= hsl_pkg::REACT_RST;
      posmode_ff <= 1'b0;
      slp_ff     <= hsl_pkg::WORD_RST;
      sln_ff     <= hsl_pkg::WORD_RST;
      target_ff  <= hsl_pkg::WORD_RST;
      zero_ff    <= hsl_pkg::WORD_RST;
      pos_ff     <= hsl_pkg::WORD_RST;
      goal_ff    <= hsl_pkg::WORD_RST;
      {dir_ff, homed_ff, fault_ff, warn_ff, terr_ff} <= 5'h00;
      {rstop_ff, run_ff, creep_ff, final_ff, edge_ff} <= 5'h00;
    end else begin
      state_ff   <= nxt_state;
      type_ff    <= nxt_type;
      react_ff   <= nxt_react;
      posmode_ff <= nxt_posmode;
      slp_ff     <= nxt_slp;
      sln_ff     <= nxt_sln;
      target_ff  <= nxt_target;
      zero_ff    <= nxt_zero;
      pos_ff     <= nxt_pos;
      goal_ff    <= nxt_goal;
      {dir_ff, homed_ff, fault_ff, warn_ff, terr_ff} <=
        {nxt_dir, nxt_homed, nxt_fault, nxt_warn, nxt_terr};
      {rstop_ff, run_ff, creep_ff, final_ff, edge_ff} <=
        {nxt_rstop, nxt_run, nxt_creep, nxt_final, nxt_edge};
    end
  end

  // Outputs straight from flip-flops
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign drive_run     = run_ff;
  assign drive_dir_pos = dir_ff;
  assign drive_creep   = creep_ff;
  assign rapid_stop    = rstop_ff;
  assign limit_fault   = fault_ff;
  assign limit_warn    = warn_ff;
  assign homing_done   = homed_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_undef_refused: assert property ( // [R13]
    ce && idle && cmd_home && !type_ok && !is_zp &&
    type_ff != hsl_pkg::HT_KEEP |=> !drive_run && terr_ff)
    else $error("undefined homing type started a move");
  chk_keep_position: assert property ( // [R16]
    ce && idle && cmd_home && type_ff == hsl_pkg::HT_KEEP
    && !inc_rise && !dec_rise |=> homing_done && pos_ff == $past(pos_ff))
    else $error("keep-position homing changed position");
  chk_zero_load: assert property ( // [R21]
    ce && state_ff == hsl_pkg::ST_ARMED && zp_rise && !cmd_stop
    |=> pos_ff == $past(zero_ff) && homing_done && !drive_run)
    else $error("zero pulse did not load the zero value");
  chk_limit_reverse: assert property ( // [R08]
    ce && state_ff == hsl_pkg::ST_SEEK && lim_here && !cmd_stop
    |=> drive_dir_pos != $past(drive_dir_pos))
    else $error("homing did not reverse at the limit switch");
  chk_edge_zero: assert property ( // [R14]
    ce && state_ff == hsl_pkg::ST_SEEK && edge_ff && !lim_here &&
    dir_ff == final_ff && qual_edge && !cmd_stop
    |=> homing_done && pos_ff == $past(zero_ff))
    else $error("edge-only homing missed its edge");
  chk_target_reject: assert property ( // [R19]
    ce && idle && (cmd_abs || cmd_rel) && posmode_ff && goal_out
    |=> !drive_run ##1 !drive_run)
    else $error("out of range target started a move");
  chk_endless_stop: assert property ( // [R20]
    ce && state_ff == hsl_pkg::ST_ENDLESS && end_hit
    |=> rapid_stop && !drive_run ##1 !rapid_stop)
    else $error("endless move passed a soft limit");
  chk_limits_gate: assert property ( // [R17]
    lim_active |-> homing_done && posmode_ff)
    else $error("soft limits active before homing");
  chk_limits_off: assert property ( // [R18]
    slp_ff == 32'sh0 && sln_ff == 32'sh0 |-> !lim_active)
    else $error("soft limits active with both values zero");
  chk_zp_start: assert property ( // [R15]
    ce && idle && cmd_home && is_zp
    |=> drive_run && drive_creep && state_ff == hsl_pkg::ST_ARMED)
    else $error("zero-pulse homing did not wait for a pulse");

  cov_homing_done: cover property (
    state_ff == hsl_pkg::ST_ARMED ##1 $rose(homing_done));
  cov_target_reject: cover property (
    idle && cmd_abs && goal_out);
  cov_endless_hit: cover property (
    state_ff == hsl_pkg::ST_ENDLESS && end_hit);
endmodule

// File: rtl/hsl_pkg.sv
// Constants and types shared by the homing and soft limit controller
package hsl_pkg;
  // ==========================================================
  // Register map (byte addresses on the APB bus)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SLP    = 8'h0c;
  localparam logic [7:0] ADDR_SLN    = 8'h10;
  localparam logic [7:0] ADDR_TARGET = 8'h14;
  localparam logic [7:0] ADDR_ZERO   = 8'h18;
  localparam logic [7:0] ADDR_POS    = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int CTRL_TYPE_LSB  = 0;
  localparam int CTRL_POSMODE   = 6;
  localparam int CTRL_REACT_LSB = 8;
  localparam int CMD_HOME       = 0;
  localparam int CMD_ABS        = 1;
  localparam int CMD_REL        = 2;
  localparam int CMD_END_POS    = 3;
  localparam int CMD_END_NEG    = 4;
  localparam int CMD_STOP       = 5;
  localparam int CMD_CLR        = 6;

  // ==========================================================
  // Reset values
  localparam logic [5:0]  TYPE_RST  = 6'h00;
  localparam logic [1:0]  REACT_RST = 2'h0;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  // ==========================================================
  // Limit fault reactions
  localparam logic [1:0] REACTION_NO_ERROR = 2'h0;
  localparam logic [1:0] REACTION_WARN     = 2'h1;

  // ==========================================================
  // Homing type codes
  localparam logic [5:0] HT_FIRST    = 6'd5;
  localparam logic [5:0] HT_MIRROR   = 6'd11;
  localparam logic [5:0] HT_LAST     = 6'd14;
  localparam logic [5:0] HT_EDGE_LO  = 6'd21;
  localparam logic [5:0] HT_EDGE_HI  = 6'd30;
  localparam logic [5:0] HT_EDGE_OFS = 6'd16;
  localparam logic [5:0] HT_MIR_OFS  = 6'd4;  // Types 11..14 reuse 7..10
  localparam logic [5:0] HT_ZP_POS   = 6'd33;
  localparam logic [5:0] HT_ZP_NEG   = 6'd34;
  localparam logic [5:0] HT_KEEP     = 6'd35;

  // Per type 5..10: {final_pos, edge_rise, trig_rise, cam_pos, nocam_pos}
  localparam logic [5:0][4:0] HT_TABLE = {
    5'b10011, 5'b01011, 5'b11001, 5'b00101, 5'b01010, 5'b10110};

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_ARMED, ST_MOVE, ST_ENDLESS
  } hsl_state_t;
endpackage

// File: tb/hsl_axis_model.sv
// Axis mechanics model: step encoder, limit switches, cam and zero pulse
`timescale 1ns/1ps
module hsl_axis_model (
  input  wire logic pclk,
  input  wire logic drive_run,
  input  wire logic drive_dir_pos,
  output logic      lim_neg_in,
  output logic      lim_pos_in,
  output logic      ref_cam_in,
  output logic      zero_pulse_in,
  output logic      step_inc_in,
  output logic      step_dec_in
);
  int pos = 0;
  int div = 0;
  // ==========================================================
  // Steps
  // One step each eight cycles, so a stop lands before the next step
  // One-cycle pulse per step, so a reversal never adds a stray count
  always @(posedge pclk) begin
    div         <= (div + 1) % 8;
    step_inc_in <= drive_run && drive_dir_pos && div == 0;
    step_dec_in <= drive_run && !drive_dir_pos && div == 0;
    if (drive_run && div == 0) begin
      pos <= drive_dir_pos ? pos + 1 : pos - 1;
    end
  end
  // ==========================================================
  // Pins
  // Switch and encoder levels follow the mechanical position
  assign lim_neg_in    = pos <= -100;
  assign lim_pos_in    = pos >= 100;
  assign ref_cam_in    = pos >= 30 && pos <= 40;
  assign zero_pulse_in = pos % 16 == 0;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the homing and soft limit controller
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seed = 32'h0000dae5;
  logic        pready, pslverr, err, run, dpos, creep, rstop, flt, wrn, hd;
  logic        ln, lp, cam, zp, si, sd;
  int          errors = 0, samples_checked = 0, stops = 0, s0, ep, zv, t;
  int          bad[4] = '{15, 16, 31, 32};
  int          ht[5] = '{8, 24, 13, 33, 35};
  int          mp[5] = '{32, 30, 32, 48, 48};
  // ==========================================================
  // Clock, stop counter, watchdog
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (rstop === 1'b1) stops <= stops + 1;
  initial begin
    #2000000;
    errors++;
    stop_test;
  end
  hsl_homing_limit DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lim_neg_in(ln), .lim_pos_in(lp), .ref_cam_in(cam),
    .zero_pulse_in(zp), .step_inc_in(si), .step_dec_in(sd),
    .drive_run(run), .drive_dir_pos(dpos), .drive_creep(creep),
    .rapid_stop(rstop), .limit_fault(flt), .limit_warn(wrn),
    .homing_done(hd));
  hsl_axis_model M (.pclk(pclk), .drive_run(run), .drive_dir_pos(dpos),
    .lim_neg_in(ln), .lim_pos_in(lp), .ref_cam_in(cam),
    .zero_pulse_in(zp), .step_inc_in(si), .step_dec_in(sd));
  // ==========================================================
  // Helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) errors++;
  endtask
  task cmd(input int b);
    apb(1'b1, hsl_pkg::ADDR_CMD, 32'h1 << b);
  endtask
  // Waits for the axis to stand still
  task settle(input int lim);
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (run !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) errors++;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (bad[i]) begin
      apb(1'b1, hsl_pkg::ADDR_CTRL, 32'(bad[i]));
      cmd(hsl_pkg::CMD_HOME);
      settle(4);
      apb(1'b0, hsl_pkg::ADDR_STATUS, 32'h0);
      chk("type_error", 32'h1, 32'(rd[6]));
      cmd(hsl_pkg::CMD_CLR);
    end
    foreach (ht[i]) begin
      zv = int'(xs() % 32'h15) - 10;
      if (ht[i] != 35) ep = zv;
      apb(1'b1, hsl_pkg::ADDR_ZERO, 32'(zv));
      apb(1'b1, hsl_pkg::ADDR_CTRL, 32'(ht[i]));
      cmd(hsl_pkg::CMD_HOME);
      @(posedge pclk);
      chk("creep", 32'(ht[i] == 8 || ht[i] == 33), 32'(creep));
      settle(20000);
      chk("homed", 32'h1, 32'(hd));
      chk("home_mech", 32'(mp[i]), 32'(M.pos));
      apb(1'b0, hsl_pkg::ADDR_POS, 32'h0);
      chk("home_pos", 32'(ep), rd);
    end
    apb(1'b1, hsl_pkg::ADDR_CTRL, 32'h40);
    apb(1'b0, hsl_pkg::ADDR_STATUS, 32'h0);
    chk("limits_off", 32'h0, 32'(rd[7]));
    apb(1'b1, hsl_pkg::ADDR_SLP, 32'h14);
    apb(1'b1, hsl_pkg::ADDR_SLN, 32'hffffffec);
    apb(1'b0, hsl_pkg::ADDR_STATUS, 32'h0);
    chk("limits_on", 32'h1, 32'(rd[7]));
    t = int'(xs() % 32'h11) - 8;
    apb(1'b1, hsl_pkg::ADDR_TARGET, 32'(t));
    cmd(hsl_pkg::CMD_ABS);
    settle(2000);
    apb(1'b0, hsl_pkg::ADDR_POS, 32'h0);
    chk("move_pos", 32'(t), rd);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, hsl_pkg::ADDR_CTRL, 32'h40 | (r << 8));
      s0 = stops;
      apb(1'b1, hsl_pkg::ADDR_TARGET, 32'h32);
      cmd(hsl_pkg::CMD_ABS);
      settle(4);
      apb(1'b0, hsl_pkg::ADDR_POS, 32'h0);
      chk("refused_pos", 32'(t), rd);
      chk("warn", 32'(r == 1), 32'(wrn));
      chk("fault_stop", {r == 2, 31'(r == 2)}, {flt, 31'(stops - s0)});
      cmd(hsl_pkg::CMD_CLR);
    end
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, hsl_pkg::ADDR_CTRL, 32'h40 | (d << 8));
      s0 = stops;
      cmd(d ? hsl_pkg::CMD_END_NEG : hsl_pkg::CMD_END_POS);
      settle(2000);
      apb(1'b0, hsl_pkg::ADDR_POS, 32'h0);
      chk("endless_pos", d ? 32'hffffffec : 32'h14, rd);
      chk("endless_stop", 32'h1, 32'(stops - s0));
      chk("endless_warn", 32'(d), 32'(wrn));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    stop_test;
  end
endmodule
